// File: hdl/flic_cfg.svh
// Constants of the four level interrupt controller
`ifndef FLIC_CFG_SVH
`define FLIC_CFG_SVH
`define FLIC_NUM_SRC 14
`define FLIC_PRIMARY_ENABLE_OFS 8'ha8
`define FLIC_LOW_PRIO_OFS 8'hb8
`define FLIC_EXT_ENABLE_OFS 8'he8
`define FLIC_HIGH_PRIO_OFS 8'hb4
`define FLIC_EXT_LOW_PRIO_OFS 8'hfc
`define FLIC_EXT_HIGH_PRIO_OFS 8'hf4
`define FLIC_FLAG_CTRL_OFS 8'h88
`define FLIC_STATUS_OFS 8'hc0
`define FLIC_REG_RESET 8'h00
`define FLIC_EXT_ENABLE_MASK 8'hf7
`define FLIC_EXT_PRIO_MASK 8'hf3
`define FLIC_B_GATE 7
`define FLIC_B_CONV 6
`define FLIC_B_BROWN 5
`define FLIC_B_SERIAL 4
`define FLIC_B_T1 3
`define FLIC_B_PIN1 2
`define FLIC_B_T0 1
`define FLIC_B_PIN0 0
`define FLIC_B_T2 7
`define FLIC_B_SPI 6
`define FLIC_B_BRAKE 5
`define FLIC_B_WDOG 4
`define FLIC_B_CAPT 2
`define FLIC_B_KEYPAD 1
`define FLIC_B_TWOWIRE 0
`define FLIC_B_CAPT_PRIO 7
`define FLIC_B_PIN0_MODE 0
`define FLIC_B_PIN0_FLAG 1
`define FLIC_B_PIN1_MODE 2
`define FLIC_B_PIN1_FLAG 3
`define FLIC_B_T0_FLAG 5
`define FLIC_B_T1_FLAG 7
`define FLIC_SAMPLE_PHASE 2'd2
`define FLIC_POLL_PHASE 2'd0
`define FLIC_LAST_PHASE 2'd3
`define FLIC_CLK_PERIOD_NS 5
`define FLIC_CLK_PER_MC 4
`define FLIC_CALL_MC 3'd4
`define FLIC_HOLD_INSTR 2'd1
`define FLIC_MAX_LATENCY_MC 12
`define FLIC_MAX_LATENCY_CLK (`FLIC_MAX_LATENCY_MC * `FLIC_CLK_PER_MC)
`define FLIC_SRC_PIN0 4'd0
`define FLIC_SRC_T0 4'd3
`define FLIC_SRC_PIN1 4'd6
`define FLIC_SRC_T1 4'd8
`define FLIC_SRC_SERIAL 9
`define FLIC_SRC_BRAKE 10
`define FLIC_VEC_PIN0 16'h0003
`define FLIC_VEC_BROWN 16'h0043
`define FLIC_VEC_WDOG 16'h0053
`define FLIC_VEC_T0 16'h000b
`define FLIC_VEC_TWOWIRE 16'h0033
`define FLIC_VEC_CONV 16'h005b
`define FLIC_VEC_PIN1 16'h0013
`define FLIC_VEC_KEYPAD 16'h003b
`define FLIC_VEC_T1 16'h001b
`define FLIC_VEC_SERIAL 16'h0023
`define FLIC_VEC_BRAKE 16'h0073
`define FLIC_VEC_SPI 16'h004b
`define FLIC_VEC_T2 16'h002b
`define FLIC_VEC_CAPT 16'h0063
`endif

// File: hdl/flic_pkg.sv
// Types of the four level interrupt controller
package flic_pkg;
  typedef enum logic [2:0] {
    FLIC_IDLE = 3'b001,
    FLIC_REQ  = 3'b010,
    FLIC_CALL = 3'b100
  } flic_seq_t;
  typedef logic [1:0] flic_level_t;
  typedef logic [3:0] flic_src_t;
endpackage

// File: hdl/flic_arb_if.sv
// Requests and grant between controller and arbiter
`timescale 1ns/1ps
interface flic_arb_if #(parameter int N = 14);
  logic [N-1:0]                  request;
  flic_pkg::flic_level_t [N-1:0] level;
  flic_pkg::flic_level_t         floor_level;
  logic                          floor_valid;
  logic                          grant_valid;
  flic_pkg::flic_src_t           grant_index;
  flic_pkg::flic_level_t         grant_level;
  modport ctrl (output request, level, floor_level, floor_valid,
                input grant_valid, grant_index, grant_level);
  modport arb (input request, level, floor_level, floor_valid,
               output grant_valid, grant_index, grant_level);
endinterface

// File: hdl/flic_arbiter.sv
// Level and fixed order arbiter
`timescale 1ns/1ps
module flic_arbiter #(
  parameter int N = 14
) (
  flic_arb_if.arb bus
);
  logic [N-1:0]          eligible;
  logic                  found;
  flic_pkg::flic_level_t best_level;
  flic_pkg::flic_src_t   best_index;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_elig
      assign eligible[g] = bus.request[g] &&
                           (!bus.floor_valid || bus.level[g] > bus.floor_level);
    end
  endgenerate

  // Highest level wins, lower index wins a tie
  always_comb
  begin
    found      = 1'b0;
    best_level = 2'd0;
    best_index = 4'd0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (eligible[i] && (!found || bus.level[i] >= best_level))
      begin
        found      = 1'b1;
        best_level = bus.level[i];
        best_index = 4'(i);
      end
    end
  end

  assign bus.grant_valid = found;
  assign bus.grant_index = best_index;
  assign bus.grant_level = best_level;
endmodule

// File: hdl/flic_top.sv
// Four level interrupt controller with Avalon-MM registers
//
// Behaviour
// - Sample pins and serial done requests at third phase; flags follow the sample.
// - Timer overflow flags set at third phase of the overflow machine cycle.
// - Flags are polled in the machine cycle after they were set.
// - Active polled request with conditions met starts a four machine cycle call.
// - At least five machine cycles from flag set to routine start.
// - No vector while equal or higher level is in service; request waits.
// - Vector only at the last machine cycle of the running instruction.
// - After enable or priority write, next instruction completes before vectoring.
// - One machine cycle is four clocks; worst latency is 48 clocks.
// - Bit 7 of primary enable gates every source globally.
// - Primary enable bit 4 gates both transmit and receive done requests.
// - Primary enable: 6 converter, 5 brownout, 3 timer one, 2 pin one, 1 timer zero, 0 pin zero.
// - Timer interrupts come from their overflow flags gated by own enable.
// - Brake interrupt only when brake flag set and extended enable bit 5.
// - Extended enable: 7 timer two, 6 SPI, 4 watchdog, 3 reserved, 2 capture, 1 keypad, 0 I2C.
// - Low priority bits give the low level bit of each primary source.
// - One capture priority bit serves all three capture channels.
// - Enables and low priority clear to zero at reset.
// - Level is high bit and low bit, 0 lowest to 3 highest.
// - Only a higher level preempts; top level is never preempted.
// - Equal level ties resolve by fixed order, pin zero first, capture last.
// - Only the service return ends the in-service level.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "flic_cfg.svh"
module flic_top #(
  parameter int NUM_SRC = `FLIC_NUM_SRC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EXT_REQUEST_PIN_ZERO_N,
  input  wire logic        EXT_REQUEST_PIN_ONE_N,
  input  wire logic        RECEIVE_DONE_FLAG,
  input  wire logic        TRANSMIT_DONE_FLAG,
  input  wire logic        TIMER_ZERO_OVERFLOW,
  input  wire logic        TIMER_ONE_OVERFLOW,
  input  wire logic        BROWNOUT_FLAG,
  input  wire logic        WATCHDOG_FLAG,
  input  wire logic        TWO_WIRE_FLAG,
  input  wire logic        CONVERTER_FLAG,
  input  wire logic        KEYPAD_FLAG,
  input  wire logic        BRAKE_FLAG,
  input  wire logic        SPI_FLAG,
  input  wire logic        TIMER_TWO_FLAG,
  input  wire logic [2:0]  CAPTURE_FLAG,
  input  wire logic        INSTR_LAST,
  input  wire logic        CALL_ACK,
  input  wire logic        SERVICE_RETURN,
  output logic             VECTOR_REQ,
  output logic      [15:0] VECTOR_ADDR,
  output logic             CALL_ACTIVE,
  output logic      [3:0]  IN_SERVICE,
  output logic      [1:0]  MC_PHASE
);
  logic [7:0]            primary_interrupt_enable;
  logic [7:0]            low_priority_select;
  logic [7:0]            extended_interrupt_enable;
  logic [7:0]            high_priority_select;
  logic [7:0]            extended_low_priority_select;
  logic [7:0]            extended_high_priority_select;
  logic [1:0]            edge_mode;
  logic [1:0]            ext_request_flag;
  logic [1:0]            pin_q;
  logic [1:0]            timer_flag;
  logic [1:0]            timer_seen;
  logic [9:0]            sampled_q;
  logic [NUM_SRC-1:0]    poll_q;
  logic [1:0]            phase;
  flic_pkg::flic_seq_t   state;
  flic_pkg::flic_seq_t   next_state;
  logic [2:0]            call_cnt;
  logic [1:0]            hold_cnt;
  logic [3:0]            in_service;
  flic_pkg::flic_src_t   grant_index_q;
  flic_pkg::flic_level_t grant_level_q;
  logic                  wait_q;

  flic_arb_if #(.N(NUM_SRC)) arb ();

  flic_arbiter #(.N(NUM_SRC)) u_arbiter (
    .bus (arb.arb)
  );

  function automatic logic flic_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  function automatic flic_pkg::flic_level_t flic_top_level(input logic [3:0] lv);
    return lv[3] ? 2'd3 : lv[2] ? 2'd2 : lv[1] ? 2'd1 : 2'd0;
  endfunction

  function automatic logic [15:0] flic_vector(input flic_pkg::flic_src_t idx);
    case (idx)
      4'd0:    return `FLIC_VEC_PIN0;
      4'd1:    return `FLIC_VEC_BROWN;
      4'd2:    return `FLIC_VEC_WDOG;
      4'd3:    return `FLIC_VEC_T0;
      4'd4:    return `FLIC_VEC_TWOWIRE;
      4'd5:    return `FLIC_VEC_CONV;
      4'd6:    return `FLIC_VEC_PIN1;
      4'd7:    return `FLIC_VEC_KEYPAD;
      4'd8:    return `FLIC_VEC_T1;
      4'd9:    return `FLIC_VEC_SERIAL;
      4'd10:   return `FLIC_VEC_BRAKE;
      4'd11:   return `FLIC_VEC_SPI;
      4'd12:   return `FLIC_VEC_T2;
      4'd13:   return `FLIC_VEC_CAPT;
      default: return `FLIC_VEC_PIN0;
    endcase
  endfunction

  // Machine cycle timing
  wire sample_now = CLK_EN && phase == `FLIC_SAMPLE_PHASE;
  wire poll_now   = CLK_EN && phase == `FLIC_POLL_PHASE;
  wire mc_end     = CLK_EN && phase == `FLIC_LAST_PHASE;
  wire instr_end  = mc_end && INSTR_LAST;

  // Register bus decode
  wire bus_req     = AVS_READ || AVS_WRITE;
  wire wr_fire     = CLK_EN && AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];
  wire hit_pen     = flic_hit(AVS_ADDRESS, `FLIC_PRIMARY_ENABLE_OFS);
  wire hit_lpr     = flic_hit(AVS_ADDRESS, `FLIC_LOW_PRIO_OFS);
  wire hit_een     = flic_hit(AVS_ADDRESS, `FLIC_EXT_ENABLE_OFS);
  wire hit_hpr     = flic_hit(AVS_ADDRESS, `FLIC_HIGH_PRIO_OFS);
  wire hit_elp     = flic_hit(AVS_ADDRESS, `FLIC_EXT_LOW_PRIO_OFS);
  wire hit_ehp     = flic_hit(AVS_ADDRESS, `FLIC_EXT_HIGH_PRIO_OFS);
  wire hit_flg     = flic_hit(AVS_ADDRESS, `FLIC_FLAG_CTRL_OFS);
  wire hit_sta     = flic_hit(AVS_ADDRESS, `FLIC_STATUS_OFS);
  wire hit_steer   = hit_pen || hit_lpr || hit_een || hit_hpr || hit_elp || hit_ehp;
  wire [7:0] wd    = AVS_WRITEDATA[7:0];
  wire [7:0] flag_byte = {timer_flag[1], 1'b0, timer_flag[0], 1'b0,
                          ext_request_flag[1], edge_mode[1], ext_request_flag[0], edge_mode[0]};
  wire [7:0] read_byte = ({8{hit_pen}} & primary_interrupt_enable) |
                         ({8{hit_lpr}} & low_priority_select) |
                         ({8{hit_een}} & extended_interrupt_enable) |
                         ({8{hit_hpr}} & high_priority_select) |
                         ({8{hit_elp}} & extended_low_priority_select) |
                         ({8{hit_ehp}} & extended_high_priority_select) |
                         ({8{hit_flg}} & flag_byte);
  wire [NUM_SRC-1:0] src_flag;
  wire [31:0] read_word = hit_sta ? {14'h0000, src_flag, in_service} : {24'h000000, read_byte};

  // Software clears of hardware set flags
  wire [1:0] sw_ext_clr   = {2{wr_fire && hit_flg}} & {wd[`FLIC_B_PIN1_FLAG], wd[`FLIC_B_PIN0_FLAG]};
  wire [1:0] sw_timer_clr = {2{wr_fire && hit_flg}} & {wd[`FLIC_B_T1_FLAG], wd[`FLIC_B_T0_FLAG]};

  // Core handshake
  wire ack       = CLK_EN && state == flic_pkg::FLIC_REQ && CALL_ACK;
  wire ret       = CLK_EN && SERVICE_RETURN && in_service != 4'h0;
  wire call_done = mc_end && state == flic_pkg::FLIC_CALL && call_cnt == `FLIC_CALL_MC - 3'd1;
  wire issue     = instr_end && state == flic_pkg::FLIC_IDLE && hold_cnt == 2'd0 &&
                   arb.grant_valid;
  wire [1:0] ack_ext_clr   = {2{ack}} & {grant_index_q == `FLIC_SRC_PIN1,
                                         grant_index_q == `FLIC_SRC_PIN0};
  wire [1:0] ack_timer_clr = {2{ack}} & {grant_index_q == `FLIC_SRC_T1,
                                         grant_index_q == `FLIC_SRC_T0};
  wire [3:0] set_mask = ack ? 4'(4'h1 << grant_level_q) : 4'h0;
  wire [3:0] clr_mask = ret ? 4'(4'h1 << flic_top_level(in_service)) : 4'h0;

  wire [1:0] ext_pin = {EXT_REQUEST_PIN_ONE_N, EXT_REQUEST_PIN_ZERO_N};
  wire [1:0] timer_ovf = {TIMER_ONE_OVERFLOW, TIMER_ZERO_OVERFLOW};

  // Pin and timer request flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_flag
      wire ext_set = sample_now && !ext_pin[g] && (!edge_mode[g] || pin_q[g]);
      wire ext_clr = edge_mode[g] ? (sw_ext_clr[g] || ack_ext_clr[g]) : (sample_now && ext_pin[g]);
      wire tmr_set = sample_now && (timer_seen[g] || timer_ovf[g]);
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          ext_request_flag[g] <= 1'b0;
          timer_flag[g]       <= 1'b0;
          timer_seen[g]       <= 1'b0;
          pin_q[g]            <= 1'b1;
        end
        else if (CLK_EN)
        begin
          ext_request_flag[g] <= ext_set || (ext_request_flag[g] && !ext_clr);
          timer_flag[g]       <= tmr_set || (timer_flag[g] &&
                                 !(sw_timer_clr[g] || ack_timer_clr[g]));
          timer_seen[g]       <= !sample_now && (timer_seen[g] || timer_ovf[g]);
          if (sample_now)
            pin_q[g] <= ext_pin[g];
        end
      end
    end
  endgenerate

  // Source order: pin0, brownout, watchdog, timer0, I2C, converter, pin1,
  // keypad, timer1, serial, brake, SPI, timer2, capture
  assign src_flag = {sampled_q[9:6], sampled_q[0], timer_flag[1], sampled_q[5],
                     ext_request_flag[1], sampled_q[4:3], timer_flag[0],
                     sampled_q[2:1], ext_request_flag[0]};
  wire [7:0] pe = primary_interrupt_enable;
  wire [7:0] xe = extended_interrupt_enable;
  wire [NUM_SRC-1:0] src_enable = {xe[`FLIC_B_CAPT], xe[`FLIC_B_T2], xe[`FLIC_B_SPI],
    xe[`FLIC_B_BRAKE], pe[`FLIC_B_SERIAL], pe[`FLIC_B_T1], xe[`FLIC_B_KEYPAD],
    pe[`FLIC_B_PIN1], pe[`FLIC_B_CONV], xe[`FLIC_B_TWOWIRE], pe[`FLIC_B_T0],
    xe[`FLIC_B_WDOG], pe[`FLIC_B_BROWN], pe[`FLIC_B_PIN0]};
  wire [7:0] lp = low_priority_select;
  wire [7:0] hp = high_priority_select;
  wire [7:0] xl = extended_low_priority_select;
  wire [7:0] xh = extended_high_priority_select;
  wire [NUM_SRC-1:0] lvl_lo = {lp[`FLIC_B_CAPT_PRIO], xl[`FLIC_B_T2], xl[`FLIC_B_SPI],
    xl[`FLIC_B_BRAKE], lp[`FLIC_B_SERIAL], lp[`FLIC_B_T1], xl[`FLIC_B_KEYPAD],
    lp[`FLIC_B_PIN1], lp[`FLIC_B_CONV], xl[`FLIC_B_TWOWIRE], lp[`FLIC_B_T0],
    xl[`FLIC_B_WDOG], lp[`FLIC_B_BROWN], lp[`FLIC_B_PIN0]};
  wire [NUM_SRC-1:0] lvl_hi = {hp[`FLIC_B_CAPT_PRIO], xh[`FLIC_B_T2], xh[`FLIC_B_SPI],
    xh[`FLIC_B_BRAKE], hp[`FLIC_B_SERIAL], hp[`FLIC_B_T1], xh[`FLIC_B_KEYPAD],
    hp[`FLIC_B_PIN1], hp[`FLIC_B_CONV], xh[`FLIC_B_TWOWIRE], hp[`FLIC_B_T0],
    xh[`FLIC_B_WDOG], hp[`FLIC_B_BROWN], hp[`FLIC_B_PIN0]};

  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_level
      assign arb.level[g] = {lvl_hi[g], lvl_lo[g]};
    end
  endgenerate

  assign arb.request     = poll_q & src_enable & {NUM_SRC{pe[`FLIC_B_GATE]}};
  assign arb.floor_valid = in_service != 4'h0;
  assign arb.floor_level = flic_top_level(in_service);

  // Call sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      flic_pkg::FLIC_IDLE: if (issue) next_state = flic_pkg::FLIC_REQ;
      flic_pkg::FLIC_REQ:  if (ack) next_state = flic_pkg::FLIC_CALL;
      flic_pkg::FLIC_CALL: if (call_done) next_state = flic_pkg::FLIC_IDLE;
      default:             next_state = flic_pkg::FLIC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      phase         <= 2'd0;
      state         <= flic_pkg::FLIC_IDLE;
      call_cnt      <= 3'd0;
      hold_cnt      <= 2'd0;
      in_service    <= 4'h0;
      grant_index_q <= 4'd0;
      grant_level_q <= 2'd0;
      sampled_q     <= 10'h000;
      poll_q        <= '0;
    end
    else if (CLK_EN)
    begin
      phase      <= phase + 2'd1;
      state      <= next_state;
      in_service <= (in_service & ~clr_mask) | set_mask;
      if (ack)
        call_cnt <= 3'd0;
      else if (mc_end && state == flic_pkg::FLIC_CALL)
        call_cnt <= call_cnt + 3'd1;
      if (wr_fire && hit_steer)
        hold_cnt <= `FLIC_HOLD_INSTR;
      else if (instr_end && hold_cnt != 2'd0)
        hold_cnt <= hold_cnt - 2'd1;
      if (issue)
      begin
        grant_index_q <= arb.grant_index;
        grant_level_q <= arb.grant_level;
      end
      if (sample_now)
        sampled_q <= {|CAPTURE_FLAG, TIMER_TWO_FLAG, SPI_FLAG, BRAKE_FLAG, KEYPAD_FLAG,
                      CONVERTER_FLAG, TWO_WIRE_FLAG, WATCHDOG_FLAG, BROWNOUT_FLAG,
                      RECEIVE_DONE_FLAG || TRANSMIT_DONE_FLAG};
      if (poll_now)
        poll_q <= src_flag;
    end
  end

  // Core facing outputs
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      VECTOR_REQ  <= 1'b0;
      VECTOR_ADDR <= 16'h0000;
      CALL_ACTIVE <= 1'b0;
    end
    else if (CLK_EN)
    begin
      VECTOR_REQ  <= issue || (VECTOR_REQ && !ack);
      CALL_ACTIVE <= ack || (CALL_ACTIVE && !call_done);
      if (issue)
        VECTOR_ADDR <= flic_vector(arb.grant_index);
    end
  end

  assign IN_SERVICE = in_service;
  assign MC_PHASE   = phase;

  // Registers and bus answer
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      primary_interrupt_enable      <= `FLIC_REG_RESET;
      low_priority_select           <= `FLIC_REG_RESET;
      extended_interrupt_enable     <= `FLIC_REG_RESET;
      high_priority_select          <= `FLIC_REG_RESET;
      extended_low_priority_select  <= `FLIC_REG_RESET;
      extended_high_priority_select <= `FLIC_REG_RESET;
      edge_mode                     <= 2'b00;
      wait_q                        <= 1'b1;
      AVS_READDATA                  <= 32'h00000000;
    end
    else if (CLK_EN)
    begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q)
        AVS_READDATA <= read_word;
      if (wr_fire && hit_pen)
        primary_interrupt_enable <= wd;
      if (wr_fire && hit_lpr)
        low_priority_select <= wd;
      if (wr_fire && hit_een)
        extended_interrupt_enable <= wd & `FLIC_EXT_ENABLE_MASK;
      if (wr_fire && hit_hpr)
        high_priority_select <= wd;
      if (wr_fire && hit_elp)
        extended_low_priority_select <= wd & `FLIC_EXT_PRIO_MASK;
      if (wr_fire && hit_ehp)
        extended_high_priority_select <= wd & `FLIC_EXT_PRIO_MASK;
      if (wr_fire && hit_flg)
        edge_mode <= {wd[`FLIC_B_PIN1_MODE], wd[`FLIC_B_PIN0_MODE]};
    end
  end

  assign AVS_WAITREQUEST = wait_q;

  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  a_serial_sample: assert property (sample_now |=>
    sampled_q[0] == $past(RECEIVE_DONE_FLAG || TRANSMIT_DONE_FLAG))
    else $error("serial request not sampled at third phase");
  a_timer_set: assert property (sample_now && TIMER_ZERO_OVERFLOW |=> timer_flag[0])
    else $error("timer zero flag not set at third phase");
  a_poll_snapshot: assert property (poll_now |=> poll_q == $past(src_flag))
    else $error("poll snapshot differs from flags");
  a_call_length: assert property ($fell(CALL_ACTIVE) |->
    $past(call_cnt) == `FLIC_CALL_MC - 3'd1 && $past(mc_end))
    else $error("call did not last four machine cycles");
  a_issue_boundary: assert property ($rose(VECTOR_REQ) |->
    $past(phase) == `FLIC_LAST_PHASE && $past(INSTR_LAST))
    else $error("vector raised outside instruction end");
  a_preempt_level: assert property (VECTOR_REQ && arb.floor_valid |->
    grant_level_q > arb.floor_level)
    else $error("vector at level not above service level");
  a_hold_write: assert property ($rose(VECTOR_REQ) |-> $past(hold_cnt) == 2'd0)
    else $error("vector during write hold off");
  a_global_gate: assert property ($rose(VECTOR_REQ) |-> $past(pe[`FLIC_B_GATE]))
    else $error("vector with global gate off");
  a_serial_gate: assert property (arb.request[`FLIC_SRC_SERIAL] |-> pe[`FLIC_B_SERIAL])
    else $error("serial request passed while disabled");
  a_brake_gate: assert property (arb.request[`FLIC_SRC_BRAKE] |->
    xe[`FLIC_B_BRAKE] && poll_q[`FLIC_SRC_BRAKE])
    else $error("brake request without flag and enable");
  a_reset_clear: assert property (disable iff (1'b0) $past(RST) |->
    pe == 8'h00 && lp == 8'h00 && xe == 8'h00)
    else $error("registers not cleared by reset");
  a_return_clear: assert property (ret && !ack |=>
    $countones(in_service) == $countones($past(in_service)) - 1)
    else $error("service return did not end one level");
  a_ack_call: assert property (ack |=> CALL_ACTIVE && !VECTOR_REQ &&
    in_service[$past(grant_level_q)])
    else $error("acknowledge did not start call");

  c_vector: cover property (ack);
  c_preempt: cover property (ack && in_service != 4'h0);
  c_return: cover property (ret);
  c_bus_write: cover property (wr_fire && hit_steer);
endmodule

// File: sim/flic_core_model.sv
// Core sequencer model that acknowledges vector calls
`timescale 1ns/1ps
module flic_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [1:0] phase,
  output logic            ack,
  output logic            last
);
  logic [1:0] wait_cnt;
  logic       last_mc;
  // Two machine cycle instructions: every other cycle ends one
  assign last = last_mc;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 2'h0;
      ack      <= 1'b0;
      last_mc  <= 1'b1;
    end
    else
    begin
      if (phase == 2'h3)
        last_mc <= !last_mc;
      ack      <= req && !ack && wait_cnt == 2'h2;
      wait_cnt <= (req && !ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// File: sim/test_four_level_interrupt_controller.sv
// Self-checking bench of the four level interrupt controller
`timescale 1ns/1ps
`include "flic_cfg.svh"
module test_four_level_interrupt_controller;
  logic        clock, rst, rd, wr, wq, vreq, cact, ack, last, sret, en;
  logic [1:0]  ph;
  logic [7:0]  addr;
  logic [31:0] wdat, rdata, rdat;
  logic [15:0] vaddr;
  logic [3:0]  insv;
  logic [16:0] fl;
  logic [39:0] r;
  int          fail_count, total_checks, cyc, n, m;
  logic [39:0] rows [15] = '{
    {16'h8100, 8'd0, `FLIC_VEC_PIN0}, {16'h8200, 8'd3, `FLIC_VEC_T0},
    {16'h8800, 8'd8, `FLIC_VEC_T1}, {16'h9000, 8'd9, `FLIC_VEC_SERIAL},
    {16'h9000, 8'd10, `FLIC_VEC_SERIAL}, {16'ha000, 8'd1, `FLIC_VEC_BROWN},
    {16'hc000, 8'd5, `FLIC_VEC_CONV}, {16'h8400, 8'd6, `FLIC_VEC_PIN1},
    {16'h8010, 8'd2, `FLIC_VEC_WDOG}, {16'h8001, 8'd4, `FLIC_VEC_TWOWIRE},
    {16'h8002, 8'd7, `FLIC_VEC_KEYPAD}, {16'h8020, 8'd11, `FLIC_VEC_BRAKE},
    {16'h8040, 8'd12, `FLIC_VEC_SPI}, {16'h8080, 8'd13, `FLIC_VEC_T2},
    {16'h8004, 8'd16, `FLIC_VEC_CAPT}};
  flic_top u_dut (.CLOCK(clock), .RST(rst), .CLK_EN(en), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq), .EXT_REQUEST_PIN_ZERO_N(!fl[0]),
    .EXT_REQUEST_PIN_ONE_N(!fl[6]), .RECEIVE_DONE_FLAG(fl[9]), .TRANSMIT_DONE_FLAG(fl[10]),
    .TIMER_ZERO_OVERFLOW(fl[3]), .TIMER_ONE_OVERFLOW(fl[8]), .BROWNOUT_FLAG(fl[1]),
    .WATCHDOG_FLAG(fl[2]), .TWO_WIRE_FLAG(fl[4]), .CONVERTER_FLAG(fl[5]),
    .KEYPAD_FLAG(fl[7]), .BRAKE_FLAG(fl[11]), .SPI_FLAG(fl[12]), .TIMER_TWO_FLAG(fl[13]),
    .CAPTURE_FLAG(fl[16:14]), .INSTR_LAST(last), .CALL_ACK(ack), .SERVICE_RETURN(sret),
    .VECTOR_REQ(vreq), .VECTOR_ADDR(vaddr), .CALL_ACTIVE(cact), .IN_SERVICE(insv),
    .MC_PHASE(ph));
  flic_core_model u_core (.clk(clock), .rst(rst), .req(vreq), .phase(ph), .ack(ack),
    .last(last));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    addr <= a;
    wdat <= {24'h00, d};
    wr   <= w;
    rd   <= !w;
    @(posedge clock);
    while (wq !== 1'b0)
      @(posedge clock);
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_vreq(output int k);
    k = 0;
    while (vreq !== 1'b1 && k < 80)
    begin
      @(posedge clock);
      k++;
    end
  endtask
  task automatic give_return();
    sret <= 1'b1;
    @(posedge clock);
    sret <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {rst, rd, wr, sret, addr, wdat, fl, cyc, fail_count, total_checks} = '0;
    rst = 1'b1;
    en = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (rows[i])
    begin
      r = rows[i];
      bus(1'b1, 8'ha8, r[39:32]);
      bus(1'b1, 8'he8, r[31:24]);
      fl[r[20:16]] <= 1'b1;
      @(posedge clock);
      if (r[20:16] == 5'd3 || r[20:16] == 5'd8)
        fl[r[20:16]] <= 1'b0;
      wait_vreq(n);
      chk("vector", vaddr, r[15:0]);
      m = 0;
      while ((m == 0 || cact === 1'b1) && n < 120)
      begin
        @(posedge clock);
        n++;
        m += (cact === 1'b1);
      end
      chk("call length", m >= 13 && m <= 16, 1);
      chk("latency", n >= 19 && n <= 48, 1);
      chk("in service", insv, 4'h1);
      fl <= '0;
      repeat (8) @(posedge clock);
      give_return();
      chk("returned", insv, 4'h0);
      $display("done vector row %0d", i);
    end
    bus(1'b1, 8'ha8, 8'h00);
    bus(1'b1, 8'he8, 8'h00);
    rst <= 1'b1;
    @(posedge clock);
    chk("reset phase", ph, 2'd0);
    rst <= 1'b0;
    @(posedge clock);
    foreach (rows[i])
    begin
      bus(1'b0, i < 5 ? 8'ha8 : i < 10 ? 8'hb8 : 8'he8, 8'h00);
      chk("reset value", rdat, 32'h0);
    end
    bus(1'b1, 8'he8, 8'hff);
    bus(1'b0, 8'he8, 8'h00);
    chk("ext enable", rdat, 32'hf7);
    bus(1'b1, 8'h20, 8'h55);
    bus(1'b0, 8'h20, 8'h00);
    chk("unmapped", rdat, 32'h0);
    bus(1'b1, 8'he8, 8'h00);
    bus(1'b1, 8'h88, 8'h05);
    bus(1'b0, 8'h88, 8'h00);
    chk("edge modes", rdat, 32'h05);
    bus(1'b1, 8'h88, 8'h00);
    en <= 1'b0;
    @(posedge clock);
    n = ph;
    repeat (4) @(posedge clock);
    chk("frozen phase", ph, n);
    en <= 1'b1;
    $display("done registers");
    bus(1'b1, 8'ha8, 8'h24);
    fl[1] <= 1'b1;
    fl[6] <= 1'b1;
    wait_vreq(n);
    chk("gate closed", n, 80);
    bus(1'b1, 8'ha8, 8'ha4);
    wait_vreq(n);
    chk("tie order", vaddr, `FLIC_VEC_BROWN);
    repeat (30) @(posedge clock);
    wait_vreq(n);
    chk("equal level", n, 80);
    bus(1'b1, 8'hb8, 8'h04);
    wait_vreq(n);
    chk("preempt", vaddr, `FLIC_VEC_PIN1);
    repeat (30) @(posedge clock);
    chk("nested", insv, 4'h3);
    bus(1'b0, 8'hc0, 8'h00);
    chk("status", rdat, 32'h423);
    fl <= '0;
    repeat (8) @(posedge clock);
    give_return();
    give_return();
    chk("all returned", insv, 4'h0);
    $display("done priority");
    end_of_test();
  end
endmodule
